/* hdl/bit_sync2.sv */
// two flip-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
module bit_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             nrst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta;

	// meta is read by the second stage only
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta   <= '0;
			sync_o <= '0;
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end

endmodule : bit_sync2

/* hdl/smbus_backlight_pkg.sv */
// constants, register map and state encoding for the backlight register bank
package smbus_backlight_pkg;

	// register command codes
	localparam logic [7:0] REG_BRIGHTNESS    = 8'h00;
	localparam logic [7:0] REG_CONTROL       = 8'h01;
	localparam logic [7:0] REG_FAULT_STATUS  = 8'h02;
	localparam logic [7:0] REG_IDENT         = 8'h03;
	localparam logic [7:0] REG_AMBIENT       = 8'h04;
	localparam logic [7:0] REG_LOWER_BOUND   = 8'h05;
	localparam logic [7:0] REG_UPPER_BOUND   = 8'h06;

	// reset values
	localparam logic [7:0] BRIGHTNESS_RESET  = 8'hff;
	localparam logic [7:0] CONTROL_RESET     = 8'h00;
	localparam logic [7:0] BOUND_RESET       = 8'h00;
	localparam logic [7:0] ZERO_BYTE         = 8'h00;

	// reserved bits 7:6 of the control byte never store a one
	localparam logic [7:0] CONTROL_WRITE_MASK = 8'h3f;
	localparam int         CTRL_LAMP_BIT      = 0;

	// fault and status field positions
	localparam int STAT_ANY_FAULT  = 0;
	localparam int STAT_OVER_TEMP  = 1;
	localparam int STAT_OVER_CUR   = 2;
	localparam int STAT_LAMP_ON    = 3;
	localparam int FAULT_LATCH_W   = 2;

	// identification byte; value is arbitrary
	localparam logic [7:0] IDENT_CODE = 8'h2a;

	// full 8-bit slave addresses for strap low and strap high
	localparam logic [7:0] ADDR8_STRAP_LOW  = 8'h58;
	localparam logic [7:0] ADDR8_STRAP_HIGH = 8'h5a;

	// bit counting on the bus, and the settle count before the strap is taken
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [1:0] STRAP_SETTLE  = 2'h3;

	// converter timing
	localparam int         CLK_PERIOD_NS = 10;
	localparam int         CONV_TIME_NS  = 1000;
	localparam int         CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [6:0] CONV_LAST     = 7'(CONV_CYCLES - 1);

	// bus engine states, gray along address, command, data
	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_ADDR      = 4'h1,
		ST_ADDR_ACK  = 4'h3,
		ST_CMD       = 4'h2,
		ST_CMD_ACK   = 4'h6,
		ST_WDATA     = 4'h7,
		ST_WDATA_ACK = 4'h5,
		ST_RDATA     = 4'h4,
		ST_RDATA_ACK = 4'hc
	} bus_state_t;

endpackage : smbus_backlight_pkg

/* hdl/smbus_backlight_register_bank.sv */
// bus slave and seven-register bank of the backlight dimming controller
`timescale 1ns/1ps
// Function
// [RULE1] ambient register returns raw converter sample always
// [RULE2] ambient value excludes scaling and limit clamping
// [RULE3] host writes brightness byte at code 0x00
// [RULE4] read of 0x00 returns stored brightness
// [RULE5] control register at 0x01 is read/write
// [RULE6] fault status at 0x02 ignores writes
// [RULE7] identification at 0x03 ignores writes
// [RULE8] writes to ambient register are discarded
// [RULE9] lower bound at 0x05 is read/write
// [RULE10] upper bound at 0x06 is read/write
// [RULE11] device is bus slave only, never initiates
// [RULE12] address 0x58 strap low, 0x5A high
// [RULE13] two-bit latch holds inverter faults
// [RULE14] lamp state and faults tracked into status
// [RULE15] converter sample held stable during conversion
// [RULE16] bound registers set the ambient input clamps
// [RULE17] seven registers control five dimming modes
// [RULE18] only byte read/write; bad commands change nothing
// [RULE19] no clock stretching, 10 to 100 kHz
// [RULE20] strap sampled once after reset, then fixed
// [RULE21] reserved bits read zero; no PEC, alert
// [RULE22] codes above seven registers: ignore, read zero
module smbus_backlight_register_bank (
	input  wire logic       CLK_I,
	input  wire logic       NRST_I,
	input  wire logic       SCL_I,
	input  wire logic       SDA_I,
	output logic            SDA_O,
	output logic            SDA_OE_N_O,
	input  wire logic       ADDRESS_SELECT_STRAP_I,
	input  wire logic [7:0] CONVERTER_DATA_I,
	output logic            TRACK_HOLD_O,
	input  wire logic       OVER_CURRENT_I,
	input  wire logic       OVER_TEMP_I,
	input  wire logic       LAMP_ON_I,
	output logic [7:0]      BRIGHTNESS_O,
	output logic [7:0]      CONTROL_O,
	output logic [7:0]      LOWER_BOUND_O,
	output logic [7:0]      UPPER_BOUND_O
);
	import smbus_backlight_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// input synchronisation

	logic [5:0] pins_sync;
	logic       scl_s;
	logic       sda_s;
	logic       strap_s;
	logic       over_cur_s;
	logic       over_temp_s;
	logic       lamp_on_s;

	bit_sync2 #(
		.WIDTH (6)
	) u_pin_sync (
		.clk_i   (CLK_I),
		.nrst_i  (NRST_I),
		.async_i ({SCL_I, SDA_I, ADDRESS_SELECT_STRAP_I, OVER_CURRENT_I, OVER_TEMP_I,
		           LAMP_ON_I}),
		.sync_o  (pins_sync)
	);

	assign {scl_s, sda_s, strap_s, over_cur_s, over_temp_s, lamp_on_s} = pins_sync;

	////////////////////////////////////////////////////////////////////////////////
	// bus edge and condition detection

	logic scl_d;
	logic sda_d;

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	// sync resets low but the idle bus is high: edges count once the strap is taken
	logic strap_taken;
	wire scl_rise   = strap_taken & scl_s & ~scl_d;
	wire scl_fall   = strap_taken & ~scl_s & scl_d;
	wire start_cond = strap_taken & scl_s & scl_d & sda_d & ~sda_s;
	wire stop_cond  = strap_taken & scl_s & scl_d & ~sda_d & sda_s;

	////////////////////////////////////////////////////////////////////////////////
	// address strap, taken once after reset release

	logic [1:0] strap_wait;
	logic       strap_high;

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			strap_wait  <= 2'h0;
			strap_taken <= 1'b0;
			strap_high  <= 1'b0;
		end else if (!strap_taken) begin
			strap_wait <= strap_wait + 2'h1;
			if (strap_wait == STRAP_SETTLE) begin
				strap_taken <= 1'b1;              // see [RULE20]
				strap_high  <= strap_s;
			end
		end
	end

	// see [RULE12]
	wire [6:0] own_addr = strap_high ? ADDR8_STRAP_HIGH[7:1] : ADDR8_STRAP_LOW[7:1];

	////////////////////////////////////////////////////////////////////////////////
	// bus engine: byte read and byte write only, slave side

	bus_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shift_in;
	logic [7:0] shift_out;
	logic [7:0] cmd;
	logic       read_dir;
	logic       sda_drive;
	logic       wr_strobe;
	logic [7:0] read_data;

	wire byte_done  = (bit_cnt == BITS_PER_BYTE);
	wire addr_match = (shift_in[7:1] == own_addr) & strap_taken;

	// sda is only ever pulled low; scl is never driven, so no stretching
	assign SDA_O      = 1'b0;                  // see [RULE19]
	assign SDA_OE_N_O = ~sda_drive;            // see [RULE11]

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			bit_cnt  <= 4'h0;
			shift_in <= 8'h00;
		end else if (start_cond) begin
			bit_cnt <= 4'h0;
		end else if (scl_rise) begin
			bit_cnt  <= bit_cnt + 4'h1;
			shift_in <= {shift_in[6:0], sda_s};
		end else if (scl_fall && (state == ST_ADDR_ACK || state == ST_CMD_ACK)) begin
			bit_cnt <= 4'h0;
		end
	end

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			state     <= ST_IDLE;
			sda_drive <= 1'b0;
			read_dir  <= 1'b0;
			cmd       <= 8'h00;
			shift_out <= 8'h00;
			wr_strobe <= 1'b0;
		end else begin
			wr_strobe <= 1'b0;
			if (start_cond) begin
				state     <= ST_ADDR;
				sda_drive <= 1'b0;
			end else if (stop_cond) begin
				state     <= ST_IDLE;
				sda_drive <= 1'b0;
			end else if (scl_fall) begin
				unique case (state)
					ST_IDLE, ST_WDATA_ACK, ST_RDATA_ACK: begin
						state     <= ST_IDLE;
						sda_drive <= 1'b0;
					end
					ST_ADDR: begin
						if (byte_done) begin
							// a foreign address sends us back to waiting for start
							state     <= addr_match ? ST_ADDR_ACK : ST_IDLE;  // see [RULE12]
							sda_drive <= addr_match;
							read_dir  <= shift_in[0];
						end
					end
					ST_ADDR_ACK: begin
						if (read_dir) begin
							state     <= ST_RDATA;
							shift_out <= read_data;
							sda_drive <= ~read_data[7];
						end else begin
							state     <= ST_CMD;
							sda_drive <= 1'b0;
						end
					end
					ST_CMD: begin
						if (byte_done) begin
							state     <= ST_CMD_ACK;
							cmd       <= shift_in;
							sda_drive <= 1'b1;
						end
					end
					ST_CMD_ACK: begin
						state     <= ST_WDATA;
						sda_drive <= 1'b0;
					end
					ST_WDATA: begin
						if (byte_done) begin
							// a write lands only once the whole data byte is in
							state     <= ST_WDATA_ACK;
							sda_drive <= 1'b1;
							wr_strobe <= 1'b1;            // see [RULE18]
						end
					end
					ST_RDATA: begin
						if (byte_done) begin
							state     <= ST_RDATA_ACK;
							sda_drive <= 1'b0;
						end else begin
							shift_out <= {shift_out[6:0], 1'b0};
							sda_drive <= ~shift_out[6];
						end
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register bank: four host-written, two internally updated, one constant

	logic [7:0] brightness_level;
	logic [7:0] device_control;
	logic [7:0] fault_status;
	logic [7:0] ambient_light_reading;
	logic [7:0] ambient_light_lower_bound;
	logic [7:0] ambient_light_upper_bound;
	logic [FAULT_LATCH_W-1:0] fault_latch;

	// read-only codes and codes past the map decode to no write enable
	wire we_brightness = wr_strobe & (cmd == REG_BRIGHTNESS);   // see [RULE3]
	wire we_control    = wr_strobe & (cmd == REG_CONTROL);      // see [RULE5]
	wire we_lower      = wr_strobe & (cmd == REG_LOWER_BOUND);  // see [RULE9]
	wire we_upper      = wr_strobe & (cmd == REG_UPPER_BOUND);  // see [RULE10]

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			brightness_level          <= BRIGHTNESS_RESET;
			device_control            <= CONTROL_RESET;
			ambient_light_lower_bound <= BOUND_RESET;
			ambient_light_upper_bound <= BOUND_RESET;
		end else begin
			if (we_brightness) brightness_level <= shift_in;
			if (we_control) device_control <= shift_in & CONTROL_WRITE_MASK;  // see [RULE21]
			if (we_lower) ambient_light_lower_bound <= shift_in;
			if (we_upper) ambient_light_upper_bound <= shift_in;
		end
	end

	// see [RULE4] [RULE6] [RULE7] [RULE17] [RULE22]
	assign read_data = (cmd == REG_BRIGHTNESS)   ? brightness_level :
	                   (cmd == REG_CONTROL)      ? device_control :
	                   (cmd == REG_FAULT_STATUS) ? fault_status :
	                   (cmd == REG_IDENT)        ? IDENT_CODE :
	                   (cmd == REG_AMBIENT)      ? ambient_light_reading :  // see [RULE1]
	                   (cmd == REG_LOWER_BOUND)  ? ambient_light_lower_bound :
	                   (cmd == REG_UPPER_BOUND)  ? ambient_light_upper_bound :
	                                               ZERO_BYTE;

	// the analog clamps and dimming path take their settings from here
	assign BRIGHTNESS_O  = brightness_level;
	assign CONTROL_O     = device_control;
	assign LOWER_BOUND_O = ambient_light_lower_bound;            // see [RULE16]
	assign UPPER_BOUND_O = ambient_light_upper_bound;            // see [RULE16]

	////////////////////////////////////////////////////////////////////////////////
	// fault latch and status; set beats clear, cleared by turning the lamp off

	wire [FAULT_LATCH_W-1:0] fault_set = {over_cur_s, over_temp_s};
	wire fault_clear = ~device_control[CTRL_LAMP_BIT];

	genvar gi;
	generate
		for (gi = 0; gi < FAULT_LATCH_W; gi++) begin : g_fault
			always_ff @(posedge CLK_I or negedge NRST_I) begin
				if (!NRST_I)
					fault_latch[gi] <= 1'b0;
				else
					fault_latch[gi] <= fault_set[gi] | (fault_latch[gi] & ~fault_clear);  // see [RULE13]
			end
		end
	endgenerate

	wire [7:0] next_fault_status = {4'h0, lamp_on_s, fault_latch, |fault_latch};

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I)
			fault_status <= ZERO_BYTE;
		else
			fault_status <= next_fault_status;     // see [RULE14]
	end

	////////////////////////////////////////////////////////////////////////////////
	// converter: hold for a full conversion, then take the raw result

	logic [6:0] conv_cnt;
	logic       hold;

	assign TRACK_HOLD_O = hold;

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			conv_cnt              <= 7'h00;
			hold                  <= 1'b0;
			ambient_light_reading <= ZERO_BYTE;
		end else if (!hold) begin
			hold     <= 1'b1;                      // see [RULE15]
			conv_cnt <= 7'h00;
		end else if (conv_cnt == CONV_LAST) begin
			hold <= 1'b0;
			// raw sample only: limits and scaling act after this point
			ambient_light_reading <= CONVERTER_DATA_I;  // see [RULE1] [RULE2] [RULE8]
		end else begin
			conv_cnt <= conv_cnt + 7'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);

	sequence s_write_done;
		wr_strobe;
	endsequence

	sequence s_addr_reject;
		state == ST_ADDR && scl_fall && byte_done && !addr_match;
	endsequence

	a_bright_write: assert property (s_write_done ##0 cmd == REG_BRIGHTNESS |=>  // see [RULE3]
		brightness_level == $past(shift_in))
		else $error("brightness write not stored");
	a_bad_write: assert property (s_write_done ##0 cmd > REG_UPPER_BOUND |=>  // see [RULE22]
		$stable(brightness_level) && $stable(device_control) &&
		$stable(ambient_light_lower_bound) && $stable(ambient_light_upper_bound))
		else $error("write to unmapped code changed a register");
	a_unmapped_zero: assert property (cmd > REG_UPPER_BOUND |-> read_data == ZERO_BYTE)  // see [RULE22]
		else $error("unmapped code reads nonzero");
	a_ident_read: assert property (cmd == REG_IDENT |-> read_data == IDENT_CODE)  // see [RULE7]
		else $error("identification read wrong");
	a_reserved_zero: assert property (device_control[7:6] == 2'h0 &&  // see [RULE21]
		fault_status[7:4] == 4'h0)
		else $error("reserved bits set");
	a_slave_drive: assert property (sda_drive |-> state inside {ST_ADDR_ACK,  // see [RULE11]
		ST_CMD_ACK, ST_WDATA_ACK, ST_RDATA})
		else $error("sda driven outside acknowledge or read data");
	a_addr_reject: assert property (s_addr_reject |=> state == ST_IDLE && !sda_drive)  // see [RULE12]
		else $error("foreign address acknowledged");
	a_strap_fixed: assert property (strap_taken |=> strap_taken && $stable(own_addr))  // see [RULE20]
		else $error("slave address changed in operation");
	a_fault_hold: assert property (fault_latch[0] && device_control[CTRL_LAMP_BIT] |=>  // see [RULE13]
		fault_latch[0])
		else $error("fault latch lost while lamp enabled");
	a_status_track: assert property (##1 fault_status[STAT_LAMP_ON] == $past(lamp_on_s) &&  // see [RULE14]
		fault_status[STAT_ANY_FAULT] == $past(|fault_latch))
		else $error("status does not track lamp or faults");
	a_hold_span: assert property ($rose(hold) |-> hold [*8])  // see [RULE15]
		else $error("track and hold released early");
	a_ambient_raw: assert property ($fell(hold) |-> ambient_light_reading ==  // see [RULE1]
		$past(CONVERTER_DATA_I))
		else $error("ambient reading not the raw sample");

endmodule : smbus_backlight_register_bank

/* tb/smbus_backlight_register_bank_bench.sv */
// self-checking bench for the backlight register bank driven by a host master model
`timescale 1ns/1ps
module smbus_backlight_register_bank_bench;
	import smbus_backlight_pkg::*;

	localparam logic [7:0] A_LO = ADDR8_STRAP_LOW;
	localparam logic [7:0] A_HI = ADDR8_STRAP_HIGH;

	logic        clk;
	logic        nrst;
	logic        strap;
	logic        over_cur;
	logic        over_temp;
	logic        lamp_on;
	logic [7:0]  conv_data;
	logic        sda_drv;
	logic        sda_oe_n;
	logic        track_hold;
	logic [7:0]  brightness;
	logic [7:0]  control;
	logic [7:0]  lower_bound;
	logic [7:0]  upper_bound;
	logic        scl;
	logic        host_sda_low;
	logic        done;
	logic [10:0] result;
	wire         sda;
	logic [7:0]  exp_reg [8];
	logic [10:0] notes [$];
	int          miscompares;
	int          n_checks;
	int          seed;

	// open-drain line with pull-up: low while either party pulls
	assign sda = ~(host_sda_low | (~sda_oe_n & ~sda_drv));

	smbus_backlight_register_bank u_smbus_backlight_register_bank (
		.CLK_I                  (clk),
		.NRST_I                 (nrst),
		.SCL_I                  (scl),
		.SDA_I                  (sda),
		.SDA_O                  (sda_drv),
		.SDA_OE_N_O             (sda_oe_n),
		.ADDRESS_SELECT_STRAP_I (strap),
		.CONVERTER_DATA_I       (conv_data),
		.TRACK_HOLD_O           (track_hold),
		.OVER_CURRENT_I         (over_cur),
		.OVER_TEMP_I            (over_temp),
		.LAMP_ON_I              (lamp_on),
		.BRIGHTNESS_O           (brightness),
		.CONTROL_O              (control),
		.LOWER_BOUND_O          (lower_bound),
		.UPPER_BOUND_O          (upper_bound)
	);

	smbus_host_model u_smbus_host_model (
		.scl_o     (scl),
		.sda_low_o (host_sda_low),
		.sda_i     (sda),
		.done_o    (done),
		.result_o  (result)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////
	task automatic cmp(input string name, input logic [10:0] e, input logic [10:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", name, e, g);
		end
	endtask : cmp

	task automatic test_done;
		if (notes.size() != 0) miscompares++;
		if (miscompares == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : test_done

	task automatic op(input logic rd, input logic [7:0] a8, input logic [7:0] c,
			input logic [7:0] wd, input logic [2:0] ea, input logic [7:0] ed);
		notes.push_back({ea, ed});
		// start off both clock edges so bus pin changes never race the synchroniser
		@(posedge clk);
		#1;
		u_smbus_host_model.xfer(rd, a8, c, wd);
	endtask : op

	task automatic read_all(input logic [7:0] a8);
		for (int c = 0; c < 8; c++) op(1'b1, a8, 8'(c), 8'h00, 3'h7, exp_reg[c]);
	endtask : read_all

	// one conversion holds for its whole length, then tracks for a single cycle
	task automatic check_hold;
		int n_hi;
		int n_lo;
		n_hi = 0;
		n_lo = 0;
		@(negedge clk);
		for (int i = 0; i < 300 && !track_hold; i++) @(negedge clk);
		for (int i = 0; i < 300 && track_hold; i++) @(negedge clk);
		for (int i = 0; i < 300 && !track_hold; i++) begin
			n_lo++;
			@(negedge clk);
		end
		for (int i = 0; i < 300 && track_hold; i++) begin
			n_hi++;
			@(negedge clk);
		end
		cmp("hold low cycles", 11'h001, 11'(n_lo));
		cmp("hold high cycles", 11'(CONV_CYCLES), 11'(n_hi));
	endtask : check_hold

	task automatic do_reset(input logic s);
		@(posedge clk);
		nrst  <= 1'b0;
		strap <= s;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		repeat (12) @(posedge clk);
		exp_reg = '{BRIGHTNESS_RESET, CONTROL_RESET, ZERO_BYTE, IDENT_CODE, conv_data,
			BOUND_RESET, BOUND_RESET, ZERO_BYTE};
	endtask : do_reset

	////////////////////////////////////////////////////////////////
	// every finished transfer is matched against the oldest note
	initial begin
		forever begin
			@(posedge done);
			if (notes.size() == 0) cmp("spare result", 11'h000, 11'h7ff);
			else cmp("bus result", notes.pop_front(), result);
		end
	end

	// a hang anywhere ends the run as a mismatch
	initial begin
		repeat (90000) @(posedge clk);
		miscompares++;
		test_done();
	end

	initial begin
		logic [7:0] wd;
		seed        = 97947;
		miscompares = 0;
		n_checks    = 0;
		nrst        = 1'b0;
		strap       = 1'b0;
		over_cur    = 1'b0;
		over_temp   = 1'b0;
		lamp_on     = 1'b0;
		conv_data   = 8'($random(seed));
		do_reset(1'b0);
		check_hold();
		read_all(A_LO);
		for (int c = 0; c < 8; c++) begin
			wd = 8'($random(seed));
			op(1'b0, A_LO, 8'(c), wd, 3'h7, 8'h00);
			if (c == 0 || c == 5 || c == 6) exp_reg[c] = wd;
			if (c == 1) exp_reg[c] = wd & CONTROL_WRITE_MASK;
		end
		@(negedge clk);
		cmp("brightness port", {3'h0, exp_reg[0]}, {3'h0, brightness});
		cmp("control port", {3'h0, exp_reg[1]}, {3'h0, control});
		cmp("lower port", {3'h0, exp_reg[5]}, {3'h0, lower_bound});
		cmp("upper port", {3'h0, exp_reg[6]}, {3'h0, upper_bound});
		// read-only and unmapped codes must still show their old contents
		read_all(A_LO);
		op(1'b0, A_LO, REG_CONTROL, 8'h01, 3'h7, 8'h00);
		exp_reg[1] = 8'h01;
		@(posedge clk);
		over_temp <= 1'b1;
		lamp_on   <= 1'b1;
		repeat (20) @(posedge clk);
		over_temp <= 1'b0;
		op(1'b1, A_LO, REG_FAULT_STATUS, 8'h00, 3'h7, 8'h0b);
		@(posedge clk);
		over_cur <= 1'b1;
		lamp_on  <= 1'b0;
		repeat (20) @(posedge clk);
		over_cur <= 1'b0;
		op(1'b1, A_LO, REG_FAULT_STATUS, 8'h00, 3'h7, 8'h07);
		op(1'b0, A_LO, REG_CONTROL, 8'h00, 3'h7, 8'h00);
		op(1'b1, A_LO, REG_FAULT_STATUS, 8'h00, 3'h7, 8'h00);
		@(posedge clk);
		conv_data <= 8'($random(seed));
		repeat (250) @(posedge clk);
		op(1'b1, A_LO, REG_AMBIENT, 8'h00, 3'h7, conv_data);
		op(1'b0, A_HI, REG_BRIGHTNESS, 8'h33, 3'h0, 8'h00);
		op(1'b1, A_LO, REG_BRIGHTNESS, 8'h00, 3'h7, exp_reg[0]);
		do_reset(1'b1);
		strap <= 1'b0;
		repeat (4) @(posedge clk);
		op(1'b1, A_HI, REG_BRIGHTNESS, 8'h00, 3'h7, BRIGHTNESS_RESET);
		op(1'b0, A_LO, REG_BRIGHTNESS, 8'h44, 3'h0, 8'h00);
		test_done();
	end
endmodule : smbus_backlight_register_bank_bench

/* tb/smbus_host_model.sv */
// host bus master model issuing byte reads and byte writes on the two-wire bus
`timescale 1ns/1ps
module smbus_host_model (
	output logic        scl_o,
	output logic        sda_low_o,
	input  wire logic   sda_i,
	output logic        done_o,
	output logic [10:0] result_o
);
	// quarter of the 125 ns bus clock; phase unrelated to the system clock
	localparam realtime QTR = 31.25;

	initial begin
		scl_o     = 1'b1;
		sda_low_o = 1'b0;
		done_o    = 1'b0;
		result_o  = 11'h000;
	end

	////////////////////////////////////////////////////////////////
	// data moves only while the bus clock is low, sampled mid-high
	task automatic bit_io(input logic b, output logic s);
		#QTR sda_low_o = ~b;
		#QTR scl_o = 1'b1;
		#QTR s = sda_i;
		#QTR scl_o = 1'b0;
	endtask : bit_io

	task automatic start_cond;
		#QTR sda_low_o = 1'b0;
		#QTR scl_o = 1'b1;
		#QTR sda_low_o = 1'b1;
		#QTR scl_o = 1'b0;
	endtask : start_cond

	task automatic stop_cond;
		#QTR sda_low_o = 1'b1;
		#QTR scl_o = 1'b1;
		#QTR sda_low_o = 1'b0;
		#QTR;
	endtask : stop_cond

	// the master releases the line in the ninth slot, so read data ends in a nack
	task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic acked);
		logic a;
		for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
		bit_io(1'b1, a);
		acked = ~a;
	endtask : byte_io

	////////////////////////////////////////////////////////////////
	// result: three ack flags (address, command, data or repeated address), read byte
	task automatic xfer(input logic rd, input logic [7:0] addr8, input logic [7:0] cmd,
			input logic [7:0] wd);
		logic [7:0] junk;
		logic [7:0] rdat;
		logic [2:0] ack;
		logic       nack;
		ack  = 3'h0;
		rdat = 8'h00;
		start_cond();
		byte_io(addr8 & 8'hfe, junk, ack[2]);
		if (ack[2]) byte_io(cmd, junk, ack[1]);
		if (ack[1] && rd) begin
			start_cond();
			byte_io(addr8 | 8'h01, junk, ack[0]);
			if (ack[0]) byte_io(8'hff, rdat, nack);
		end else if (ack[1]) begin
			byte_io(wd, junk, ack[0]);
		end
		stop_cond();
		result_o = {ack, rdat};
		done_o   = 1'b1;
		#QTR done_o = 1'b0;
	endtask : xfer
endmodule : smbus_host_model
